// ==== pkg/ssp_map.vh ====
`ifndef SSP_MAP_VH
`define SSP_MAP_VH

// ==========================================================
// I/O space addresses
`define SSP_ADDR_DATA 16'hfff0
`define SSP_ADDR_CTRL 16'hfff1

// ==========================================================
// Control register fields
`define SSP_BIT_EMU_FREE 15
`define SSP_BIT_EMU_SOFT 14
`define SSP_BIT_TX_DONE 13
`define SSP_BIT_RX_AVAIL 12
`define SSP_BIT_TX_THR_HI 11
`define SSP_BIT_TX_THR_LO 10
`define SSP_BIT_RX_THR_HI 9
`define SSP_BIT_RX_THR_LO 8
`define SSP_BIT_RX_OVERRUN 7
`define SSP_BIT_PIN_SENSE 6
`define SSP_BIT_TX_CLEAR_N 5
`define SSP_BIT_RX_CLEAR_N 4
`define SSP_BIT_FS_INTERNAL 3
`define SSP_BIT_CLK_INTERNAL 2
`define SSP_BIT_BURST 1
`define SSP_BIT_LOOP 0

// Writable bits and reset value
`define SSP_CTRL_WMASK 16'hcf3f
`define SSP_CTRL_RESET 16'h0030

// ==========================================================
// Sizes and timing
`define SSP_WORD_BITS 5'h10
`define SSP_FIFO_DEPTH 3'h4
`define SSP_CPU_CLK_NS 10
`define SSP_PORT_RST_CYCLES 5'h10
`define SSP_CLK_DIV 2

`endif

// ==== logic/ssp_sync.v ====
`timescale 1ns/10ps
`default_nettype none

module ssp_sync #(
  parameter W = 5
) (
  input wire ref_clk,
  input wire nrst,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  // ==========================================================
  // Two-flop synchroniser per pin
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= din[i];
          sync_reg <= meta_reg;
        end
      end
      assign dout[i] = sync_reg;
    end
  endgenerate

endmodule // ssp_sync

`default_nettype wire

// ==== logic/ssp_fifo.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ssp_map.vh"

module ssp_fifo (
  input wire ref_clk,
  input wire nrst,
  input wire clear,
  input wire push,
  input wire [15:0] wdata,
  input wire pop,
  output wire [15:0] rdata,
  output wire [2:0] count
);

  // ==========================================================
  // Pointers and occupancy
  reg [1:0] wptr_reg;
  reg [1:0] rptr_reg;
  reg [2:0] count_reg;
  wire full = (count_reg == `SSP_FIFO_DEPTH);
  wire empty = (count_reg == 3'h0);
  wire do_push = push & ~full;
  wire do_pop = pop & ~empty;
  wire [15:0] mem_word [0:3];

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wptr_reg <= 2'h0;
      rptr_reg <= 2'h0;
      count_reg <= 3'h0;
    end else if (clear) begin
      wptr_reg <= 2'h0;
      rptr_reg <= 2'h0;
      count_reg <= 3'h0;
    end else begin
      if (do_push)
        wptr_reg <= wptr_reg + 2'h1;
      if (do_pop)
        rptr_reg <= rptr_reg + 2'h1;
      if (do_push & ~do_pop)
        count_reg <= count_reg + 3'h1;
      else if (do_pop & ~do_push)
        count_reg <= count_reg - 3'h1;
    end
  end

  // ==========================================================
  // Storage, one register per entry
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_entry
      reg [15:0] word_reg;
      always @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
          word_reg <= 16'h0000;
        else if (do_push && (wptr_reg == i))
          word_reg <= wdata;
      end
      assign mem_word[i] = word_reg;
    end
  endgenerate

  assign rdata = mem_word[rptr_reg];
  assign count = count_reg;

endmodule // ssp_fifo

`default_nettype wire

// ==== logic/ssp_port.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ssp_map.vh"

module ssp_port (
  input wire ref_clk,
  input wire nrst,
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [15:0] io_wdata,
  output reg [15:0] io_rdata,
  input wire tx_bit_clock_in,
  output reg tx_bit_clock_out,
  output reg tx_bit_clock_oe,
  input wire tx_frame_pulse_in,
  output reg tx_frame_pulse_out,
  output reg tx_frame_pulse_oe,
  output reg tx_serial_out,
  input wire rx_bit_clock,
  input wire rx_frame_pulse,
  input wire rx_serial_in,
  output reg tx_service_irq,
  output reg rx_service_irq
);

  // ==========================================================
  // States
  localparam TX_IDLE = 1'b0;
  localparam TX_SHIFT = 1'b1;
  localparam RX_IDLE = 1'b0;
  localparam RX_SHIFT = 1'b1;

  // ==========================================================
  // Port reset sequencing
  reg [4:0] rst_cnt_reg;
  wire port_run = (rst_cnt_reg == `SSP_PORT_RST_CYCLES);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      rst_cnt_reg <= 5'h00;
    else if (!port_run)
      rst_cnt_reg <= rst_cnt_reg + 5'h01;
  end

  // ==========================================================
  // Pin synchronisers
  wire [4:0] pin_sync;

  ssp_sync #(.W(5)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din({tx_bit_clock_in, tx_frame_pulse_in, rx_bit_clock, rx_frame_pulse, rx_serial_in}),
    .dout(pin_sync)
  );

  wire txclk_s = pin_sync[4];
  wire txfs_s = pin_sync[3];
  wire rxclk_s = pin_sync[2];
  wire rxfs_s = pin_sync[1];
  wire rxd_s = pin_sync[0];

  // Previous levels for edge finding; synced copies only
  reg txclk_prev_reg;
  reg rxclk_prev_reg;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txclk_prev_reg <= 1'b0;
      rxclk_prev_reg <= 1'b0;
    end else begin
      txclk_prev_reg <= txclk_s;
      rxclk_prev_reg <= rxclk_s;
    end
  end

  // ==========================================================
  // Control register
  reg [15:0] ctrl_reg;
  wire cfg_tx_clear_n = ctrl_reg[`SSP_BIT_TX_CLEAR_N];
  wire cfg_rx_clear_n = ctrl_reg[`SSP_BIT_RX_CLEAR_N];
  wire cfg_fs_int = ctrl_reg[`SSP_BIT_FS_INTERNAL];
  wire cfg_clk_int = ctrl_reg[`SSP_BIT_CLK_INTERNAL];
  wire cfg_burst = ctrl_reg[`SSP_BIT_BURST];
  wire [1:0] tx_thr = {ctrl_reg[`SSP_BIT_TX_THR_HI], ctrl_reg[`SSP_BIT_TX_THR_LO]};
  wire [1:0] rx_thr = {ctrl_reg[`SSP_BIT_RX_THR_HI], ctrl_reg[`SSP_BIT_RX_THR_LO]};

  wire wr_ctrl = io_wr && (io_addr == `SSP_ADDR_CTRL);
  wire wr_data = io_wr && (io_addr == `SSP_ADDR_DATA);
  wire rd_ctrl = io_rd && (io_addr == `SSP_ADDR_CTRL);
  wire rd_data = io_rd && (io_addr == `SSP_ADDR_DATA);

  // Clear bits, mode flags and thresholds are stored; status bits are live
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      ctrl_reg <= `SSP_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= io_wdata & `SSP_CTRL_WMASK;
  end

  // Buffers cleared by clear bits or port reset; mode bits untouched
  wire tx_hold = ~port_run | ~cfg_tx_clear_n;
  wire rx_hold = ~port_run | ~cfg_rx_clear_n;

  // ==========================================================
  // Buffers
  wire [15:0] txf_head;
  wire [2:0] txf_count;
  wire [15:0] rxf_head;
  wire [2:0] rxf_count;
  reg txf_pop;
  reg rxf_push;
  reg [15:0] rxf_wdata;

  ssp_fifo u_tx_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clear(tx_hold),
    .push(wr_data),
    .wdata(io_wdata),
    .pop(txf_pop),
    .rdata(txf_head),
    .count(txf_count)
  );

  ssp_fifo u_rx_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clear(rx_hold),
    .push(rxf_push),
    .wdata(rxf_wdata),
    .pop(rd_data),
    .rdata(rxf_head),
    .count(rxf_count)
  );

  // ==========================================================
  // Bit clock source
  reg clk_div_reg;

  // Toggling each cycle gives half the CPU rate, the fastest allowed
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      clk_div_reg <= 1'b0;
    else if (cfg_clk_int && port_run)
      clk_div_reg <= ~clk_div_reg;
    else
      clk_div_reg <= 1'b0;
  end

  // Edge events only; no counters on the pin, so any slow clock works
  wire tx_rise = cfg_clk_int ? (port_run & ~clk_div_reg) : (txclk_s & ~txclk_prev_reg);
  wire rx_fall = rxclk_prev_reg & ~rxclk_s;

  // ==========================================================
  // Transmitter
  reg tx_state_reg;
  reg [15:0] tx_shifter_reg;
  reg [4:0] tx_bits_reg;
  reg fs_out_reg;
  reg dx_reg;

  wire tx_have = (txf_count != 3'h0);
  wire tx_start = tx_have && (cfg_fs_int || txfs_s);

  always @* begin
    txf_pop = 1'b0;
    if (!tx_hold && tx_rise) begin
      if (tx_state_reg == TX_IDLE)
        txf_pop = tx_start;
      else if (tx_bits_reg == `SSP_WORD_BITS)
        txf_pop = tx_have && !cfg_burst;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_state_reg <= TX_IDLE;
      tx_shifter_reg <= 16'h0000;
      tx_bits_reg <= 5'h00;
      fs_out_reg <= 1'b0;
      dx_reg <= 1'b0;
    end else if (tx_hold) begin
      tx_state_reg <= TX_IDLE;
      tx_bits_reg <= 5'h00;
      fs_out_reg <= 1'b0;
    end else if (tx_rise) begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_start) begin
            dx_reg <= txf_head[15];
            tx_shifter_reg <= {txf_head[14:0], 1'b0};
            tx_bits_reg <= 5'h01;
            fs_out_reg <= cfg_fs_int;
            tx_state_reg <= TX_SHIFT;
          end else begin
            fs_out_reg <= 1'b0;
          end
        end
        TX_SHIFT: begin
          fs_out_reg <= 1'b0;
          if (tx_bits_reg == `SSP_WORD_BITS) begin
            if (tx_have && !cfg_burst) begin
              // Next word follows with no new frame pulse
              dx_reg <= txf_head[15];
              tx_shifter_reg <= {txf_head[14:0], 1'b0};
              tx_bits_reg <= 5'h01;
            end else begin
              // One word per pulse in burst mode; an empty buffer also ends the frame
              tx_state_reg <= TX_IDLE;
              tx_bits_reg <= 5'h00;
            end
          end else begin
            dx_reg <= tx_shifter_reg[15];
            tx_shifter_reg <= {tx_shifter_reg[14:0], 1'b0};
            tx_bits_reg <= tx_bits_reg + 5'h01;
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  wire tx_done = (tx_state_reg == TX_IDLE) && !tx_have;

  // ==========================================================
  // Receiver
  reg rx_state_reg;
  reg [15:0] rx_shifter_reg;
  reg [4:0] rx_bits_reg;
  reg overrun_reg;
  wire [15:0] rx_word = {rx_shifter_reg[14:0], rxd_s};
  wire rx_last = (rx_state_reg == RX_SHIFT) && (rx_bits_reg == `SSP_WORD_BITS - 5'h01);

  always @* begin
    rxf_push = 1'b0;
    rxf_wdata = rx_word;
    if (!rx_hold && rx_fall && rx_last)
      rxf_push = 1'b1;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state_reg <= RX_IDLE;
      rx_shifter_reg <= 16'h0000;
      rx_bits_reg <= 5'h00;
      overrun_reg <= 1'b0;
    end else if (rx_hold) begin
      rx_state_reg <= RX_IDLE;
      rx_bits_reg <= 5'h00;
      overrun_reg <= 1'b0;
    end else if (rx_fall) begin
      case (rx_state_reg)
        RX_IDLE: begin
          if (rxfs_s) begin
            rx_shifter_reg <= {15'h0000, rxd_s};
            rx_bits_reg <= 5'h01;
            rx_state_reg <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          rx_shifter_reg <= rx_word;
          if (rx_last) begin
            // A full buffer drops the word and flags it
            if (rxf_count == `SSP_FIFO_DEPTH)
              overrun_reg <= 1'b1;
            rx_bits_reg <= 5'h00;
            if (cfg_burst)
              rx_state_reg <= RX_IDLE;
          end else begin
            rx_bits_reg <= rx_bits_reg + 5'h01;
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Service requests
  // Level n: transmit asks at n words or fewer, receive at n+1 or more
  wire tx_cond = port_run && cfg_tx_clear_n && (txf_count <= {1'b0, tx_thr});
  wire rx_cond = port_run && cfg_rx_clear_n && (rxf_count >= ({1'b0, rx_thr} + 3'h1));
  reg tx_cond_reg;
  reg rx_cond_reg;

  // Pulse on entry only, so a held level cannot re-flag after the handler
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_cond_reg <= 1'b0;
      rx_cond_reg <= 1'b0;
      tx_service_irq <= 1'b0;
      rx_service_irq <= 1'b0;
    end else begin
      tx_cond_reg <= tx_cond;
      rx_cond_reg <= rx_cond;
      tx_service_irq <= tx_cond & ~tx_cond_reg;
      rx_service_irq <= rx_cond & ~rx_cond_reg;
    end
  end

  // ==========================================================
  // Pin drivers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_bit_clock_out <= 1'b0;
      tx_bit_clock_oe <= 1'b0;
      tx_frame_pulse_out <= 1'b0;
      tx_frame_pulse_oe <= 1'b0;
      tx_serial_out <= 1'b0;
    end else begin
      tx_bit_clock_out <= clk_div_reg;
      tx_bit_clock_oe <= port_run & cfg_clk_int;
      tx_frame_pulse_out <= fs_out_reg;
      tx_frame_pulse_oe <= port_run & cfg_fs_int;
      tx_serial_out <= dx_reg;
    end
  end

  // ==========================================================
  // Read port
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 16'h0000;
    end else if (rd_data) begin
      io_rdata <= rxf_head;
    end else if (rd_ctrl) begin
      io_rdata <= ctrl_reg;
      io_rdata[`SSP_BIT_TX_DONE] <= tx_done;
      io_rdata[`SSP_BIT_RX_AVAIL] <= (rxf_count != 3'h0);
      io_rdata[`SSP_BIT_RX_OVERRUN] <= overrun_reg;
      io_rdata[`SSP_BIT_PIN_SENSE] <= rxclk_s;
    end
  end

endmodule // ssp_port

`default_nettype wire

// ==== verification/ssp_port_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ssp_map.vh"

// ==========================================================
// Port-level checker
module ssp_port_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  input wire logic tx_bit_clock_oe,
  input wire logic tx_frame_pulse_out,
  input wire logic tx_frame_pulse_oe,
  input wire logic tx_serial_out,
  input wire logic tx_service_irq,
  input wire logic rx_service_irq
);
  logic [4:0] hold_cnt;
  logic [15:0] ctrl_sh;
  logic [5:0] gap_cnt;
  wire done = (hold_cnt == `SSP_PORT_RST_CYCLES);

  // ==========================================================
  // Helper state: hold counter, control shadow, frame spacing
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt <= 5'h00;
      ctrl_sh <= `SSP_CTRL_RESET;
      gap_cnt <= 6'h3f;
    end else begin
      if (!done) begin
        hold_cnt <= hold_cnt + 5'h01;
      end
      if (io_wr && io_addr == `SSP_ADDR_CTRL) begin
        ctrl_sh <= io_wdata;
      end
      if ($rose(tx_frame_pulse_out)) begin
        gap_cnt <= 6'h00;
      end else if (gap_cnt != 6'h3f) begin
        gap_cnt <= gap_cnt + 6'h01;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Properties
  property p_port_hold;
    !done |-> !tx_bit_clock_oe && !tx_frame_pulse_oe && !tx_service_irq && !rx_service_irq;
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port active during hold");

  property p_clk_oe;
    (done && $stable(ctrl_sh[2]))[*3] |-> tx_bit_clock_oe == ctrl_sh[2];
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock pin direction wrong");

  property p_fs_oe;
    (done && $stable(ctrl_sh[3]))[*3] |-> tx_frame_pulse_oe == ctrl_sh[3];
  endproperty
  a_fs_oe: assert property (p_fs_oe) else $error("frame pin direction wrong");

  property p_bit_rate;
    $changed(tx_serial_out) |=> $stable(tx_serial_out);
  endproperty
  a_bit_rate: assert property (p_bit_rate) else $error("data faster than half clock");

  property p_frame_width;
    $rose(tx_frame_pulse_out) |-> tx_frame_pulse_oe ##1 tx_frame_pulse_out ##1 !tx_frame_pulse_out;
  endproperty
  a_frame_width: assert property (p_frame_width) else $error("frame pulse width wrong");

  property p_frame_gap;
    $rose(tx_frame_pulse_out) |-> gap_cnt >= 6'h1f;
  endproperty
  a_frame_gap: assert property (p_frame_gap) else $error("frame pulses too close");

  property p_tx_irq;
    tx_service_irq |=> !tx_service_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("transmit request not a pulse");

  property p_rx_irq;
    rx_service_irq |=> !rx_service_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive request not a pulse");

  property p_rdata_hold;
    !io_rd |=> $stable(io_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule // ssp_port_checker

bind ssp_port ssp_port_checker u_checker (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .io_addr(io_addr),
  .io_wr(io_wr),
  .io_rd(io_rd),
  .io_wdata(io_wdata),
  .io_rdata(io_rdata),
  .tx_bit_clock_oe(tx_bit_clock_oe),
  .tx_frame_pulse_out(tx_frame_pulse_out),
  .tx_frame_pulse_oe(tx_frame_pulse_oe),
  .tx_serial_out(tx_serial_out),
  .tx_service_irq(tx_service_irq),
  .rx_service_irq(rx_service_irq)
);
`default_nettype wire

// ==== verification/ssp_codec.sv ====
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Far-side codec model
module ssp_codec (
  input wire logic ref_clk,
  input wire logic tx_serial_out,
  input wire logic tx_frame_pulse_out,
  output var logic tx_bit_clock,
  output var logic tx_frame_pulse,
  output var logic rx_bit_clock,
  output var logic rx_frame_pulse,
  output var logic rx_serial_in
);
  logic [15:0] got_q[$];

  initial begin
    tx_bit_clock = 1'b0;
    tx_frame_pulse = 1'b0;
    rx_bit_clock = 1'b0;
    rx_frame_pulse = 1'b0;
    rx_serial_in = 1'b0;
  end

  // Clock stands still between calls; odd offset keeps phase unrelated
  task send_word(input logic [15:0] w, input logic fs);
    integer i;
    #3;
    for (i = 15; i >= 0; i--) begin
      rx_bit_clock = 1'b1;
      rx_serial_in = w[i];
      rx_frame_pulse = fs && (i == 15);
      #40;
      rx_bit_clock = 1'b0;
      #40;
    end
    rx_serial_in = ~w[0];
  endtask

  // Far end owns transmit clock and frame; each bit read just before a rise
  task clock_word;
    integer i;
    logic [15:0] w;
    @(posedge ref_clk);
    #3;
    for (i = 0; i < 17; i++) begin
      w = {w[14:0], tx_serial_out};
      tx_bit_clock = 1'b1;
      tx_frame_pulse = (i == 0);
      #40;
      tx_bit_clock = 1'b0;
      tx_frame_pulse = 1'b0;
      #40;
    end
    got_q.push_back(w);
  endtask

  // Bits read just after each change, two CPU cycles apart
  task get_words(input integer n, input logic burst);
    integer k;
    integer i;
    integer t;
    logic [15:0] w;
    for (k = 0; k < n; k++) begin
      t = 0;
      while ((k == 0 || burst) && !tx_frame_pulse_out && t < 3000) begin
        @(posedge ref_clk);
        #1;
        t++;
      end
      for (i = 15; i >= 0; i--) begin
        w[i] = tx_serial_out;
        repeat (2) @(posedge ref_clk);
        #1;
      end
      got_q.push_back(w);
    end
  endtask
endmodule // ssp_codec
`default_nettype wire

// ==== verification/test_ssp_port.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ssp_map.vh"

module test_ssp_port;
  logic ref_clk, nrst, io_wr, io_rd, fp_d, ck_l;
  logic [15:0] io_addr, io_wdata, rd, w;
  wire [15:0] io_rdata;
  wire ck_out, ck_oe, fp_out, fp_oe, sd_out, rx_ck, rx_fp, rx_sd, tx_irq, rx_irq, tx_ck, tx_fp;
  integer error_cnt, num_checks, tx_irq_n, rx_irq_n, fp_n, k, seed;
  logic [15:0] txq[$];
  logic [15:0] rxq[$];

  ssp_port dut (.ref_clk(ref_clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .tx_bit_clock_in(tx_ck),
    .tx_bit_clock_out(ck_out), .tx_bit_clock_oe(ck_oe), .tx_frame_pulse_in(tx_fp),
    .tx_frame_pulse_out(fp_out), .tx_frame_pulse_oe(fp_oe), .tx_serial_out(sd_out),
    .rx_bit_clock(rx_ck), .rx_frame_pulse(rx_fp), .rx_serial_in(rx_sd),
    .tx_service_irq(tx_irq), .rx_service_irq(rx_irq));
  ssp_codec codec (.ref_clk(ref_clk), .tx_serial_out(sd_out), .tx_frame_pulse_out(fp_out),
    .tx_bit_clock(tx_ck), .tx_frame_pulse(tx_fp),
    .rx_bit_clock(rx_ck), .rx_frame_pulse(rx_fp), .rx_serial_in(rx_sd));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    fp_d <= fp_out;
    if (tx_irq) tx_irq_n++;
    if (rx_irq) rx_irq_n++;
    if (fp_out && !fp_d) fp_n++;
  end

  // ==========================================================
  // Shared tasks
  task check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    io_wr = 1'b0;
  endtask

  task rdr(input logic [15:0] a);
    @(posedge ref_clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    io_rd = 1'b0;
    rd = io_rdata;
  endtask

  // Model: a full transmit buffer drops the word
  task txw(input logic [15:0] d);
    wr(`SSP_ADDR_DATA, d);
    if (txq.size() < 4) txq.push_back(d);
  endtask

  task rxw(input logic fs, input logic keep);
    w = 16'($random(seed));
    codec.send_word(w, fs);
    if (keep && rxq.size() < 4) rxq.push_back(w);
  endtask

  task pull_rx;
    rdr(`SSP_ADDR_DATA);
    check("rx word", rxq.pop_front(), rd);
  endtask

  task give_verdict;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    $display("[ERR] run end expected done seen hung");
    error_cnt++;
    give_verdict;
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h7a15;
    {error_cnt, num_checks, tx_irq_n, rx_irq_n, fp_n} = 0;
    {io_wr, io_rd, fp_d, nrst} = 4'h0;
    io_addr = 16'h0000;
    io_wdata = 16'h0000;
    repeat (4) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    rdr(`SSP_ADDR_CTRL);
    check("ctrl reset", `SSP_CTRL_RESET, rd & 16'hdfff);
    wr(`SSP_ADDR_CTRL, 16'h0038);
    wr(`SSP_ADDR_DATA, 16'hdead);
    repeat (16) @(posedge ref_clk);
    // Prefill with no bit clock; fifth word finds the buffer full
    tx_irq_n = 0;
    for (k = 0; k < 5; k++) txw(16'($random(seed)));
    fp_n = 0;
    fork
      codec.get_words(4, 1'b0);
      wr(`SSP_ADDR_CTRL, 16'h003c);
    join
    repeat (8) @(posedge ref_clk);
    for (k = 0; k < 4; k++) check("tx word", txq.pop_front(), codec.got_q.pop_front());
    check("frames cont", 16'h0001, fp_n[15:0]);
    check("tx irq", 16'h0001, tx_irq_n[15:0]);
    wr(`SSP_ADDR_CTRL, 16'h003e);
    fp_n = 0;
    fork
      codec.get_words(2, 1'b1);
      begin
        txw(16'($random(seed)));
        txw(16'($random(seed)));
      end
    join
    for (k = 0; k < 2; k++) check("tx burst", txq.pop_front(), codec.got_q.pop_front());
    check("frames burst", 16'h0002, fp_n[15:0]);
    // Internal bit clock flips every CPU cycle, both pins driven
    ck_l = ck_out;
    @(posedge ref_clk);
    #1;
    check("pin dir int", {14'h0, ~ck_l, 1'b1}, {14'h0, ck_out, ck_oe & fp_oe});
    // Receive: one frame, five words, fifth overruns
    wr(`SSP_ADDR_CTRL, 16'h033c);
    rx_irq_n = 0;
    for (k = 0; k < 5; k++) rxw(k == 0, 1'b1);
    repeat (8) @(posedge ref_clk);
    check("rx irq", 16'h0001, rx_irq_n[15:0]);
    rdr(`SSP_ADDR_CTRL);
    check("rx status", 16'h1080, rd & 16'h1080);
    for (k = 0; k < 4; k++) pull_rx;
    rdr(`SSP_ADDR_CTRL);
    check("rx empty", 16'h0080, rd & 16'h1080);
    // Unframed word lands in continuous mode, then the clear must drop it
    rxw(1'b0, 1'b0);
    wr(`SSP_ADDR_CTRL, 16'h032c);
    wr(`SSP_ADDR_CTRL, 16'h033c);
    rdr(`SSP_ADDR_CTRL);
    check("rx clear", 16'h033c, rd & 16'h1fbf);
    // Burst receive: an unframed word must be ignored
    wr(`SSP_ADDR_CTRL, 16'h033e);
    rxw(1'b1, 1'b1);
    rxw(1'b1, 1'b1);
    rxw(1'b0, 1'b0);
    repeat (8) @(posedge ref_clk);
    pull_rx;
    pull_rx;
    rdr(`SSP_ADDR_CTRL);
    check("no stray", 16'h0000, rd & 16'h1000);
    // Far end clocks and frames one slow burst word
    wr(`SSP_ADDR_CTRL, 16'h0032);
    txw(16'($random(seed)));
    check("pin dir ext", 16'h0000, {14'h0, ck_oe, fp_oe});
    codec.clock_word;
    check("tx ext", txq.pop_front(), codec.got_q.pop_front());
    give_verdict;
  end
endmodule // test_ssp_port
`default_nettype wire
